// [core/msps_defs.vh]
// Constants of the multi-segment position sequencer
`ifndef MSPS_DEFS_VH
`define MSPS_DEFS_VH
// ********************************
// Timing
// ********************************
`define MSPS_CLK_NS        32'h0000000A
`define MSPS_MS_NS         32'h000F4240
`define MSPS_MS_PER_S      10'h3E8
// ********************************
// Register byte addresses
// ********************************
`define MSPS_A_POS         8'h00
`define MSPS_A_SPEED       8'h04
`define MSPS_A_ACCEL       8'h08
`define MSPS_A_IDLE        8'h0C
`define MSPS_A_DEC1        8'h10
`define MSPS_A_DEC2        8'h14
`define MSPS_A_TRIG        8'h18
`define MSPS_A_NEXT        8'h1C
`define MSPS_A_SRC         8'h20
`define MSPS_A_UNIT        8'h24
`define MSPS_A_STAT        8'h28
// ********************************
// Reset values and limits
// ********************************
`define MSPS_POS_RST       32'h00002710
`define MSPS_POS_MIN       32'h80000001
`define MSPS_POS_NEG_OVF   32'h80000000
`define MSPS_SPEED_RST     16'h01F4
`define MSPS_SPEED_MAX     16'h7FFF
`define MSPS_TIME_RST      16'h01F4
`define MSPS_TIME_MAX      16'hFFFF
`define MSPS_IDLE_RST      16'h0001
`define MSPS_IDLE_MAX      16'h7FFF
`define MSPS_TRIG_RST      16'h0001
`define MSPS_TRIG_MAX      16'h0003
`define MSPS_NEXT_RST      16'h0000
`define MSPS_NEXT_MAX      16'h0001
`define MSPS_SRC_RST       16'h0000
`define MSPS_SRC_MAX       16'h0004
`define MSPS_UNIT_RST      16'h0000
`define MSPS_UNIT_MAX      16'h0001
// ********************************
// Fields and codes
// ********************************
`define MSPS_TRIG_EDGE     0
`define MSPS_TRIG_HOLD     1
`define MSPS_SRC_STORED    16'h0000
`define MSPS_SRC_AIN1      16'h0001
`define MSPS_SRC_AIN2      16'h0002
`define MSPS_SRC_AIN3      16'h0003
`define MSPS_SRC_PULSE     16'h0004
`define MSPS_LAST_SEG      4'hF
`define MSPS_ST_IDLE       2'h0
`define MSPS_ST_ISSUE      2'h1
`define MSPS_ST_WAIT       2'h2
`define MSPS_ST_DWELL      2'h3
`endif

// [core/msps_cfg_reg.v]
// Clamping configuration register
`timescale 1ns/10ps
`default_nettype none
module msps_cfg_reg #(
    parameter         W   = 16,
    parameter [W-1:0] RST = {W{1'b0}},
    parameter [W-1:0] MAX = {W{1'b1}}
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         we_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_ff
);
    // ********************************
    // Storage
    // ********************************
    // Out-of-range writes saturate so the profile never sees an illegal value
    always @(posedge clk_i) begin
        if (rst_i) begin
            q_ff <= RST;
        end else if (we_i) begin
            q_ff <= (d_i > MAX) ? MAX : d_i;
        end
    end
endmodule
`default_nettype wire

// [core/msps_seq.v]
// Multi-segment position sequencer with Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
`include "msps_defs.vh"
module msps_seq #(
    parameter MS_CYCLES = `MSPS_MS_NS / `MSPS_CLK_NS
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        run_trigger_i,
    input  wire        run_retrigger_input_i,
    input  wire        seg_from_di_i,
    input  wire [3:0]  di_seg_sel_i,
    input  wire        seg_done_i,
    input  wire [15:0] analog_in_one_i,
    input  wire [15:0] analog_in_two_i,
    input  wire [15:0] analog_in_three_i,
    input  wire [15:0] pulse_rate_i,
    output reg         seg_issue_o,
    output reg  [3:0]  seg_sel_o,
    output reg  [31:0] seg_pos_o,
    output reg  [15:0] seg_speed_o,
    output reg  [15:0] seg_accel_o,
    output reg  [15:0] seg_decel1_o,
    output reg  [15:0] seg_decel2_o,
    output reg         run_active_o
);
    // ********************************
    // Declarations
    // ********************************
    wire [15:0] speed_q;
    wire [15:0] accel_q;
    wire [15:0] idle_q;
    wire [15:0] dec1_q;
    wire [15:0] dec2_q;
    wire [15:0] trig_q;
    wire [15:0] next_q;
    wire [15:0] src_q;
    wire [15:0] unit_q;
    reg  [31:0] pos_ff;
    reg  [31:0] rd_val;
    reg  [31:0] wr_val;
    wire [31:0] sel_mask;
    wire        wr_en;
    reg  [19:0] ms_cnt_ff;
    reg         ms_tick_ff;
    reg  [9:0]  s_cnt_ff;
    reg         s_tick_ff;
    wire        unit_tick;
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [15:0] dwell_ff;
    reg         trig_q_ff;
    reg         retrig_q_ff;
    reg  [3:0]  di_q_ff;
    wire        trig_rise;
    wire        retrig_rise;
    wire        di_change;
    wire        start_req;
    wire        stop_req;
    reg  [15:0] src_speed;

    // ********************************
    // Wishbone slave
    // ********************************
    // Ack one cycle after the strobe; the write lands on the ack edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= rd_val;
            end
        end
    end

    assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Read mux; unmapped addresses read zero and ignore writes
    always @* begin
        case (wb_adr_i)
            `MSPS_A_POS:   rd_val = pos_ff;
            `MSPS_A_SPEED: rd_val = {16'h0000, speed_q};
            `MSPS_A_ACCEL: rd_val = {16'h0000, accel_q};
            `MSPS_A_IDLE:  rd_val = {16'h0000, idle_q};
            `MSPS_A_DEC1:  rd_val = {16'h0000, dec1_q};
            `MSPS_A_DEC2:  rd_val = {16'h0000, dec2_q};
            `MSPS_A_TRIG:  rd_val = {16'h0000, trig_q};
            `MSPS_A_NEXT:  rd_val = {16'h0000, next_q};
            `MSPS_A_SRC:   rd_val = {16'h0000, src_q};
            `MSPS_A_UNIT:  rd_val = {16'h0000, unit_q};
            `MSPS_A_STAT:  rd_val = {24'h000000, seg_sel_o,
                                     1'b0, run_active_o, state_ff};
            default:       rd_val = 32'h00000000;
        endcase
    end

    // Byte lanes not selected keep their old contents
    always @* begin
        wr_val = (rd_val & ~sel_mask) | (wb_dat_i & sel_mask);
    end

    // ********************************
    // Parameter registers
    // ********************************
    // The one unrepresentable negative value is pulled back into range
    always @(posedge clk_i) begin
        if (rst_i) begin
            pos_ff <= `MSPS_POS_RST;
        end else if (wr_en && wb_adr_i == `MSPS_A_POS) begin
            pos_ff <= (wr_val == `MSPS_POS_NEG_OVF) ? `MSPS_POS_MIN : wr_val;
        end
    end

    msps_cfg_reg #(.W(16), .RST(`MSPS_SPEED_RST), .MAX(`MSPS_SPEED_MAX)) u_speed (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (wr_en && wb_adr_i == `MSPS_A_SPEED),
        .d_i   (wr_val[15:0]),
        .q_ff  (speed_q)
    );
    msps_cfg_reg #(.W(16), .RST(`MSPS_TIME_RST), .MAX(`MSPS_TIME_MAX)) u_accel (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (wr_en && wb_adr_i == `MSPS_A_ACCEL),
        .d_i   (wr_val[15:0]),
        .q_ff  (accel_q)
    );
    msps_cfg_reg #(.W(16), .RST(`MSPS_IDLE_RST), .MAX(`MSPS_IDLE_MAX)) u_idle (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (wr_en && wb_adr_i == `MSPS_A_IDLE),
        .d_i   (wr_val[15:0]),
        .q_ff  (idle_q)
    );
    msps_cfg_reg #(.W(16), .RST(`MSPS_TIME_RST), .MAX(`MSPS_TIME_MAX)) u_dec1 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (wr_en && wb_adr_i == `MSPS_A_DEC1),
        .d_i   (wr_val[15:0]),
        .q_ff  (dec1_q)
    );
    msps_cfg_reg #(.W(16), .RST(`MSPS_TIME_RST), .MAX(`MSPS_TIME_MAX)) u_dec2 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (wr_en && wb_adr_i == `MSPS_A_DEC2),
        .d_i   (wr_val[15:0]),
        .q_ff  (dec2_q)
    );
    msps_cfg_reg #(.W(16), .RST(`MSPS_TRIG_RST), .MAX(`MSPS_TRIG_MAX)) u_trig (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (wr_en && wb_adr_i == `MSPS_A_TRIG),
        .d_i   (wr_val[15:0]),
        .q_ff  (trig_q)
    );
    msps_cfg_reg #(.W(16), .RST(`MSPS_NEXT_RST), .MAX(`MSPS_NEXT_MAX)) u_next (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (wr_en && wb_adr_i == `MSPS_A_NEXT),
        .d_i   (wr_val[15:0]),
        .q_ff  (next_q)
    );
    msps_cfg_reg #(.W(16), .RST(`MSPS_SRC_RST), .MAX(`MSPS_SRC_MAX)) u_src (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (wr_en && wb_adr_i == `MSPS_A_SRC),
        .d_i   (wr_val[15:0]),
        .q_ff  (src_q)
    );
    msps_cfg_reg #(.W(16), .RST(`MSPS_UNIT_RST), .MAX(`MSPS_UNIT_MAX)) u_unit (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (wr_en && wb_adr_i == `MSPS_A_UNIT),
        .d_i   (wr_val[15:0]),
        .q_ff  (unit_q)
    );

    // ********************************
    // Time base
    // ********************************
    // Free-running ticks; the first unit of a dwell may therefore be short
    always @(posedge clk_i) begin
        if (rst_i) begin
            ms_cnt_ff  <= 20'h00000;
            ms_tick_ff <= 1'b0;
            s_cnt_ff   <= 10'h000;
            s_tick_ff  <= 1'b0;
        end else begin
            ms_tick_ff <= (ms_cnt_ff == MS_CYCLES[19:0] - 20'h00001);
            ms_cnt_ff  <= (ms_cnt_ff == MS_CYCLES[19:0] - 20'h00001) ?
                          20'h00000 : ms_cnt_ff + 20'h00001;
            s_tick_ff  <= 1'b0;
            if (ms_tick_ff) begin
                s_tick_ff <= (s_cnt_ff == `MSPS_MS_PER_S - 10'h001);
                s_cnt_ff  <= (s_cnt_ff == `MSPS_MS_PER_S - 10'h001) ?
                             10'h000 : s_cnt_ff + 10'h001;
            end
        end
    end

    assign unit_tick = unit_q[0] ? s_tick_ff : ms_tick_ff;

    // ********************************
    // Trigger detection
    // ********************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            trig_q_ff   <= 1'b0;
            retrig_q_ff <= 1'b0;
            di_q_ff     <= 4'h0;
        end else begin
            trig_q_ff   <= run_trigger_i;
            retrig_q_ff <= run_retrigger_input_i;
            di_q_ff     <= di_seg_sel_i;
        end
    end

    assign trig_rise   = run_trigger_i & ~trig_q_ff;
    assign retrig_rise = run_retrigger_input_i & ~retrig_q_ff;
    assign di_change   = seg_from_di_i & (di_seg_sel_i != di_q_ff);

    // Level mode runs while the trigger is high; edge mode needs a rising edge
    assign start_req =
        (trig_q[`MSPS_TRIG_EDGE] ? trig_rise :
         (run_trigger_i && state_ff == `MSPS_ST_IDLE)) |
        (di_change & ~trig_q[`MSPS_TRIG_HOLD]) |
        (seg_from_di_i & trig_q[`MSPS_TRIG_HOLD] & retrig_rise);
    assign stop_req  = ~trig_q[`MSPS_TRIG_EDGE] & ~run_trigger_i;

    // ********************************
    // Segment sequencer
    // ********************************
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `MSPS_ST_IDLE: begin
                if (start_req) begin
                    nxt_state = `MSPS_ST_ISSUE;
                end
            end
            `MSPS_ST_ISSUE: begin
                nxt_state = next_q[0] ? `MSPS_ST_DWELL :
                            `MSPS_ST_WAIT;
            end
            `MSPS_ST_WAIT: begin
                if (seg_done_i) begin
                    nxt_state = `MSPS_ST_DWELL;
                end
            end
            `MSPS_ST_DWELL: begin
                // Live compare, so a new idle time acts at once
                if (dwell_ff >= idle_q) begin
                    nxt_state = `MSPS_ST_ISSUE;
                end
            end
            default: begin
                nxt_state = `MSPS_ST_IDLE;
            end
        endcase
        // Stop wins over a start in the same cycle
        if (stop_req) begin
            nxt_state = `MSPS_ST_IDLE;
        end else if (start_req) begin
            nxt_state = `MSPS_ST_ISSUE;
        end
    end

    // State, dwell counter and issue pulse
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff     <= `MSPS_ST_IDLE;
            dwell_ff     <= 16'h0000;
            seg_issue_o  <= 1'b0;
            seg_sel_o    <= `MSPS_LAST_SEG;
            run_active_o <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            run_active_o <= (nxt_state != `MSPS_ST_IDLE);
            seg_issue_o  <= (state_ff == `MSPS_ST_ISSUE);
            if (state_ff == `MSPS_ST_ISSUE) begin
                seg_sel_o <= seg_from_di_i ? di_seg_sel_i : `MSPS_LAST_SEG;
            end
            if (state_ff != `MSPS_ST_DWELL) begin
                dwell_ff <= 16'h0000;
            end else if (unit_tick && dwell_ff != `MSPS_TIME_MAX) begin
                dwell_ff <= dwell_ff + 16'h0001;
            end
        end
    end

    // ********************************
    // Speed source and profile outputs
    // ********************************
    // Unsupported third analog input gives zero speed
    always @* begin
        case (src_q)
            `MSPS_SRC_STORED: src_speed = speed_q;
            `MSPS_SRC_AIN1:   src_speed = analog_in_one_i;
            `MSPS_SRC_AIN2:   src_speed = analog_in_two_i;
            `MSPS_SRC_AIN3:   src_speed = 16'h0000;
            `MSPS_SRC_PULSE:  src_speed = pulse_rate_i;
            default:          src_speed = 16'h0000;
        endcase
    end

    // Outputs track the registers every cycle, not only at issue
    always @(posedge clk_i) begin
        if (rst_i) begin
            seg_pos_o    <= `MSPS_POS_RST;
            seg_speed_o  <= `MSPS_SPEED_RST;
            seg_accel_o  <= `MSPS_TIME_RST;
            seg_decel1_o <= `MSPS_TIME_RST;
            seg_decel2_o <= `MSPS_TIME_RST;
        end else begin
            seg_pos_o    <= pos_ff;
            seg_speed_o  <= (src_speed > `MSPS_SPEED_MAX) ?
                            `MSPS_SPEED_MAX : src_speed;
            seg_accel_o  <= accel_q;
            seg_decel1_o <= dec1_q;
            seg_decel2_o <= dec2_q;
        end
    end
endmodule
`default_nettype wire

// [dv/msps_seq_asserts.sv]
// Port-level assertions for the multi-segment position sequencer
`timescale 1ns/10ps
`default_nettype none
`include "msps_defs.vh"
module msps_seq_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        run_trigger_i,
    input wire logic        run_retrigger_input_i,
    input wire logic        seg_from_di_i,
    input wire logic        seg_done_i,
    input wire logic        seg_issue_o,
    input wire logic [31:0] seg_pos_o,
    input wire logic        run_active_o
);
    logic [1:0] typ_ff;
    logic       cond_ff;
    logic       done_ff;
    logic       iss_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Mirror trigger type and next condition from bus writes (bench writes in range only)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            typ_ff  <= 2'h1;
            cond_ff <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == `MSPS_A_TRIG) begin
            typ_ff <= wb_dat_i[1:0];
        end else if (wb_ack_o && wb_we_i && wb_adr_i == `MSPS_A_NEXT) begin
            cond_ff <= wb_dat_i[0];
        end
    end
    // Finish seen since the last issue, and an issue seen in this run
    always_ff @(posedge clk_i) begin
        if (rst_i || seg_issue_o) done_ff <= 1'b0;
        else if (seg_done_i) done_ff <= 1'b1;
        if (rst_i || !run_active_o) iss_ff <= 1'b0;
        else if (seg_issue_o) iss_ff <= 1'b1;
    end
    AST_ACK_ONCE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack is not a single pulse");
    AST_POS_RANGE: assert property (seg_pos_o != `MSPS_POS_NEG_OVF)
        else $error("position count outside its range");
    AST_ISSUE_RUN: assert property (seg_issue_o |-> $past(run_active_o))
        else $error("segment issued while not running");
    AST_LEVEL_STOP: assert property (!typ_ff[0] && run_active_o && !run_trigger_i |-> ##[1:3] !run_active_o)
        else $error("level mode run did not stop");
    AST_EDGE_START: assert property (typ_ff[0] && $rose(run_trigger_i) |-> ##[1:3] seg_issue_o)
        else $error("rising trigger did not issue");
    AST_EDGE_HOLD: assert property (typ_ff[0] && run_active_o |=> run_active_o)
        else $error("edge mode run stopped");
    AST_DI_HOLD: assert property (typ_ff == 2'h3 && !run_active_o && !run_trigger_i
        && !$past(run_trigger_i) && !run_retrigger_input_i && !$past(run_retrigger_input_i)
        |=> !run_active_o)
        else $error("run started without a trigger");
    // A rising trigger two cycles back restarts at issue, so it is left out here
    AST_COND0_DONE: assert property (!cond_ff && seg_issue_o && iss_ff && !seg_from_di_i
        && !($past(run_trigger_i, 2) && !$past(run_trigger_i, 3)) |-> done_ff)
        else $error("next segment issued before output finished");
    cover property (seg_issue_o && cond_ff);
    cover property (seg_issue_o && seg_from_di_i);
    cover property ($fell(run_active_o));
endmodule
bind msps_seq msps_seq_asserts i_msps_seq_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .run_trigger_i(run_trigger_i),
    .run_retrigger_input_i(run_retrigger_input_i), .seg_from_di_i(seg_from_di_i),
    .seg_done_i(seg_done_i), .seg_issue_o(seg_issue_o), .seg_pos_o(seg_pos_o),
    .run_active_o(run_active_o));
`default_nettype wire

// [dv/msps_prof_model.sv]
// Behavioural motion profile generator answering issued segments
`timescale 1ns/10ps
`default_nettype none
module msps_prof_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       seg_issue_i,
    input  wire logic [7:0] delay_i,
    output var  logic       seg_done_o
);
    logic [7:0] cnt_ff;
    logic       busy_ff;
    // Output lasts delay_i + 1 cycles after the issue is sampled; a long delay models a slow axis
    always_ff @(posedge clk_i) begin
        seg_done_o <= 1'b0;
        if (rst_i) begin
            busy_ff <= 1'b0;
        end else if (seg_issue_i) begin
            busy_ff <= 1'b1;
            cnt_ff  <= delay_i;
        end else if (busy_ff && cnt_ff == 8'h00) begin
            busy_ff    <= 1'b0;
            seg_done_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
endmodule
`default_nettype wire

// [dv/test_msps_seq.sv]
// Self-checking testbench of the multi-segment position sequencer
`timescale 1ns/10ps
`default_nettype none
`include "msps_defs.vh"
module test_msps_seq;
    localparam logic [31:0] RSTV [10] = '{32'h2710, 32'h1F4, 32'h1F4, 32'h1, 32'h1F4,
                                          32'h1F4, 32'h1, 32'h0, 32'h0, 32'h0};
    localparam logic [7:0]  LA [4] = '{`MSPS_A_POS, `MSPS_A_POS, `MSPS_A_SPEED, `MSPS_A_ACCEL};
    localparam logic [31:0] LD [4] = '{32'hFFFFFFFF, 32'h80000000, 32'hFFFF, 32'hFFFF};
    localparam logic [31:0] LE [4] = '{32'hFFFFFFFF, 32'h80000001, 32'h7FFF, 32'hFFFF};
    localparam logic [15:0] SV [5] = '{16'h0100, 16'h0123, 16'h0234, 16'h0000, 16'h0789};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd;
    logic        trig = 1'b0;
    logic        retrig = 1'b0;
    logic        fdi = 1'b0;
    logic        h;
    logic [3:0]  dsel = 4'h0;
    logic [7:0]  dly = 8'h04;
    wire  [31:0] rdat, pos;
    wire  [15:0] spd, acc, dc1, dc2;
    wire  [3:0]  sel;
    wire         ack, done, iss, act;
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;
    always #5 clk_i = ~clk_i;
    msps_seq #(.MS_CYCLES(10)) i_msps_seq (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .run_trigger_i(trig), .run_retrigger_input_i(retrig),
        .seg_from_di_i(fdi), .di_seg_sel_i(dsel), .seg_done_i(done),
        .analog_in_one_i(SV[1]), .analog_in_two_i(SV[2]), .analog_in_three_i(16'h0456),
        .pulse_rate_i(SV[4]), .seg_issue_o(iss), .seg_sel_o(sel), .seg_pos_o(pos),
        .seg_speed_o(spd), .seg_accel_o(acc), .seg_decel1_o(dc1), .seg_decel2_o(dc2),
        .run_active_o(act));
    msps_prof_model i_msps_prof_model (.clk_i(clk_i), .rst_i(rst_i), .seg_issue_i(iss),
        .delay_i(dly), .seg_done_o(done));
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; held until ack is sampled, then released
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task wiss(input int lim);
        h = 1'b0;
        for (int i = 0; i < lim && !h; i++) begin
            @(posedge clk_i);
            h = (iss === 1'b1);
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    task t_regs;
        chk(pos, 32'h00002710);
        chk({spd, acc}, 32'h01F401F4);
        chk({dc1, dc2}, 32'h01F401F4);
        for (int i = 0; i < 10; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, RSTV[i]);
        end
        // Status after reset: last segment selected, not running, idle
        wb(1'b0, `MSPS_A_STAT, 32'h0);
        chk(rd, 32'h000000F0);
        wb(1'b1, 8'h40, 32'hFFFF);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
    endtask
    task t_limits;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, LA[i], LD[i]);
            wb(1'b0, LA[i], 32'h0);
            chk(rd, LE[i]);
        end
        chk(pos, 32'h80000001);
    endtask
    task t_src;
        wb(1'b1, `MSPS_A_SPEED, {16'h0, SV[0]});
        for (int s = 0; s < 5; s++) begin
            wb(1'b1, `MSPS_A_SRC, s);
            wb(1'b0, `MSPS_A_SRC, 32'h0);
            chk(spd, SV[s]);
        end
        wb(1'b1, `MSPS_A_SRC, 32'h0);
    endtask
    task t_trig;
        trig <= 1'b1;
        wiss(5);
        chk({h, sel}, {1'b1, `MSPS_LAST_SEG});
        trig <= 1'b0;
        wiss(40);
        chk({h, act}, 2'b11);
        wb(1'b1, `MSPS_A_TRIG, 32'h0);
        wb(1'b0, `MSPS_A_TRIG, 32'h0);
        chk(act, 1'b0);
        trig <= 1'b1;
        wiss(5);
        chk(h, 1'b1);
        trig <= 1'b0;
        wb(1'b0, `MSPS_A_TRIG, 32'h0);
        chk(act, 1'b0);
    endtask
    task t_cond1;
        dly <= 8'hC8;
        wb(1'b1, `MSPS_A_NEXT, 32'h1);
        wb(1'b1, `MSPS_A_TRIG, 32'h1);
        trig <= 1'b1;
        wiss(5);
        trig <= 1'b0;
        wiss(20);
        chk({h, done}, 2'b10);
        wb(1'b1, `MSPS_A_TRIG, 32'h0);
        // Idle counted in seconds: no reissue within 300 cycles; ticks free-run,
        // so this window must stay well clear of the first seconds tick
        wb(1'b1, `MSPS_A_UNIT, 32'h1);
        wb(1'b1, `MSPS_A_TRIG, 32'h1);
        trig <= 1'b1;
        wiss(5);
        chk(h, 1'b1);
        trig <= 1'b0;
        wiss(300);
        chk(h, 1'b0);
        wb(1'b1, `MSPS_A_TRIG, 32'h0);
        wb(1'b1, `MSPS_A_UNIT, 32'h0);
        wb(1'b1, `MSPS_A_NEXT, 32'h0);
        dly <= 8'h04;
    endtask
    task t_di;
        fdi <= 1'b1;
        wb(1'b1, `MSPS_A_TRIG, 32'h1);
        dsel <= 4'h5;
        wiss(6);
        chk({h, sel}, 5'h15);
        wb(1'b1, `MSPS_A_TRIG, 32'h0);
        wb(1'b1, `MSPS_A_TRIG, 32'h3);
        dsel <= 4'h9;
        wiss(20);
        chk(h, 1'b0);
        retrig <= 1'b1;
        wiss(6);
        chk({h, sel}, 5'h19);
        retrig <= 1'b0;
        wb(1'b1, `MSPS_A_TRIG, 32'h0);
        fdi <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_limits;
        t_src;
        t_trig;
        t_cond1;
        t_di;
        report_and_stop;
    end
    // Cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop;
        end
    end
endmodule
`default_nettype wire
